// file: shared/sct_pkg.sv
// timing counters and activation sequencer: shared constants and types
// assumes a 32-bit apb slave with one register per aligned word
package sct_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_GT_HIGH = 8'h00;
  localparam logic [7:0] ADDR_GT_LOW = 8'h04;
  localparam logic [7:0] ADDR_WT_B3 = 8'h08;
  localparam logic [7:0] ADDR_WT_B2 = 8'h0C;
  localparam logic [7:0] ADDR_WT_B1 = 8'h10;
  localparam logic [7:0] ADDR_WT_B0 = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_ETU = 8'h20;
  // control field positions
  localparam int CTRL_BGT_EN = 0;
  localparam int CTRL_WT_EN = 1;
  localparam int CTRL_UART = 2;
  localparam int CTRL_WARM = 3;
  localparam int CTRL_DEACT = 4;
  // reset values, and guard counter start loads
  localparam logic [7:0] RST_GT_HIGH = 8'h00;
  localparam logic [7:0] RST_GT_LOW = 8'h0C;
  localparam logic [7:0] RST_WT_B3 = 8'h00;
  localparam logic [7:0] RST_WT_B2 = 8'h00;
  localparam logic [7:0] RST_WT_B1 = 8'h25;
  localparam logic [7:0] RST_WT_B0 = 8'h80;
  localparam logic [10:0] RST_ETU = 11'h174;
  localparam logic [8:0] GT_INIT = 9'h001;
  localparam logic [8:0] BGT_INIT = 9'h000;
  // card clock timing, in card clocks; CK_DIV in mclk cycles per half card clock
  localparam int TB_CLOCKS = 200;
  localparam int TE_CLOCKS = 401;
  localparam int ATR_MIN_CLOCKS = 400;
  localparam int ATR_MAX_CLOCKS = 40000;
  localparam int VCC_SETTLE_CLOCKS = 64;
  localparam int CK_DIV = 25;
  typedef enum logic [2:0] {
    ACT_OFF = 3'b000,
    ACT_POWER = 3'b001,
    ACT_CLOCK = 3'b010,
    ACT_ATR = 3'b011,
    ACT_RUN = 3'b100,
    ACT_WARM = 3'b101,
    ACT_DEACT = 3'b110
  } sct_act_type;
  typedef struct packed {
    logic rst_n;
    logic clk_en;
    logic vcc_en;
    logic io_rx;
  } sct_card_type;
endpackage

// file: verilog/sct_timing.sv
// timing counters and power-on/off sequencer of a card interface
// assumes start-of-character strobes from the shifter, synchronous to mclk
//
// Function
// - guard counter loads one at terminal start
// - guard counts etus to value, then permits
// - guard registers read programmed value only
// - block guard cleared at card character start
// - block guard counts to shadow, then permits
// - shadow captured on enable rising edge
// - block guard delay up to 512 etus
// - 32-bit waiting counter decrements per etu
// - expiry raises event and locks interface
// - byte2 write loads counter while disabled
// - uart mode reloads counter on start bit
// - enable edges start/stop; after timeout, a rise restarts only once unlocked
// - power only with card; detection starts cold
// - cold: reset low, supply, clock, release
// - watch atr from 400 to 40000 clocks
// - warm reset holds reset low 400+ clocks
// - deactivation and overcurrent handling
// - etu generator counts card clocks, pulses
// - card removal starts deactivation
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module sct_timing (
  input wire logic mclk, // 100 mhz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic card_present, // card detect pin
  input wire logic overcurrent, // supply fault pin
  input wire logic io_in, // card i/o level
  input wire logic tx_start, // terminal character start
  input wire logic rx_start, // card character start
  output logic tx_permit, // terminal may transmit
  output logic wt_timeout, // waiting time expiry pulse
  output logic if_locked, // rx/tx disabled
  output logic atr_seen, // answer-to-reset in window
  output logic atr_late, // no answer by window end
  output logic card_clock, // card clock pin
  output logic card_rst_n, // card reset pin, low active
  output logic card_vcc_en, // card supply enable
  output logic io_oe // i/o driver enable, low here
);
  // ==========================================================
  // apb registers
  logic [7:0] gt_high_ff, gt_low_ff, wt_b3_ff, wt_b2_ff, wt_b1_ff, wt_b0_ff;
  logic [4:0] ctrl_ff;
  logic [10:0] etu_ff;
  logic wr_en, hit;
  logic pres_ff;
  logic [31:0] nxt_rdata;
  sct_pkg::sct_act_type act_ff;
  logic [8:0] gt_cnt_ff, bgt_cnt_ff, bgt_shadow_ff;
  logic [31:0] wt_cnt_ff;
  logic wt_run_ff, lock_ff;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  always_comb begin
    hit = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      // guard value readback, not the live count
      sct_pkg::ADDR_GT_HIGH: nxt_rdata = {24'h00_0000, gt_high_ff};
      sct_pkg::ADDR_GT_LOW: nxt_rdata = {24'h00_0000, gt_low_ff};
      sct_pkg::ADDR_WT_B3: nxt_rdata = {24'h00_0000, wt_b3_ff};
      sct_pkg::ADDR_WT_B2: nxt_rdata = {24'h00_0000, wt_b2_ff};
      sct_pkg::ADDR_WT_B1: nxt_rdata = {24'h00_0000, wt_b1_ff};
      sct_pkg::ADDR_WT_B0: nxt_rdata = {24'h00_0000, wt_b0_ff};
      sct_pkg::ADDR_CTRL: nxt_rdata = {27'h000_0000, ctrl_ff};
      sct_pkg::ADDR_STAT: nxt_rdata = {25'h000_0000, act_ff, lock_ff,
                                       wt_run_ff, tx_permit, pres_ff};
      sct_pkg::ADDR_ETU: nxt_rdata = {21'h00_0000, etu_ff};
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= nxt_rdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gt_high_ff <= sct_pkg::RST_GT_HIGH;
      gt_low_ff <= sct_pkg::RST_GT_LOW;
      wt_b3_ff <= sct_pkg::RST_WT_B3;
      wt_b2_ff <= sct_pkg::RST_WT_B2;
      wt_b1_ff <= sct_pkg::RST_WT_B1;
      wt_b0_ff <= sct_pkg::RST_WT_B0;
      ctrl_ff <= 5'h00;
      etu_ff <= sct_pkg::RST_ETU;
    end else if (wr_en) begin
      unique case (paddr)
        sct_pkg::ADDR_GT_HIGH: gt_high_ff <= pwdata[7:0];
        sct_pkg::ADDR_GT_LOW: gt_low_ff <= pwdata[7:0];
        sct_pkg::ADDR_WT_B3: wt_b3_ff <= pwdata[7:0];
        sct_pkg::ADDR_WT_B2: wt_b2_ff <= pwdata[7:0];
        sct_pkg::ADDR_WT_B1: wt_b1_ff <= pwdata[7:0];
        sct_pkg::ADDR_WT_B0: wt_b0_ff <= pwdata[7:0];
        sct_pkg::ADDR_CTRL: ctrl_ff <= pwdata[4:0];
        sct_pkg::ADDR_ETU: etu_ff <= pwdata[10:0];
        default: ;
      endcase
    end
  end
  logic bgt_en, wt_en, uart_mode;
  logic [8:0] gt_value;
  logic [31:0] wt_value;
  assign bgt_en = ctrl_ff[sct_pkg::CTRL_BGT_EN];
  assign wt_en = ctrl_ff[sct_pkg::CTRL_WT_EN];
  assign uart_mode = ctrl_ff[sct_pkg::CTRL_UART];
  assign gt_value = {gt_high_ff[0], gt_low_ff};
  assign wt_value = {wt_b3_ff, wt_b2_ff, wt_b1_ff, wt_b0_ff};
  // ==========================================================
  // pin synchronisers and card clock
  logic [2:0] pres_sync_ff, oc_sync_ff, io_sync_ff;
  logic oc_ff, io_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pres_sync_ff <= 3'h0;
      oc_sync_ff <= 3'h0;
      io_sync_ff <= 3'h7;
      pres_ff <= 1'b0;
      oc_ff <= 1'b0;
      io_ff <= 1'b1;
    end else begin
      pres_sync_ff <= {pres_sync_ff[1:0], card_present};
      oc_sync_ff <= {oc_sync_ff[1:0], overcurrent};
      io_sync_ff <= {io_sync_ff[1:0], io_in};
      if (pres_sync_ff[1] == pres_sync_ff[2]) pres_ff <= pres_sync_ff[2];
      if (oc_sync_ff[1] == oc_sync_ff[2]) oc_ff <= oc_sync_ff[2];
      if (io_sync_ff[1] == io_sync_ff[2]) io_ff <= io_sync_ff[2];
    end
  end
  // card clock as mclk / (2*CK_DIV); ck_tick marks each rising edge
  logic [4:0] ck_div_ff;
  logic ck_ff, ck_tick, ck_run;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ck_div_ff <= 5'h00;
      ck_ff <= 1'b0;
    end else if (ck_div_ff == 5'(sct_pkg::CK_DIV - 1)) begin
      ck_div_ff <= 5'h00;
      ck_ff <= ~ck_ff;
    end else begin
      ck_div_ff <= ck_div_ff + 5'h01;
    end
  end
  assign ck_tick = (ck_div_ff == 5'(sct_pkg::CK_DIV - 1)) & ~ck_ff;
  // etu: count card clocks up to programmed divisor
  logic [10:0] etu_cnt_ff;
  logic etu_tick;
  assign etu_tick = ck_tick & (etu_cnt_ff >= etu_ff - 11'h001);
  always_ff @(posedge mclk) begin
    if (sys_rst | ~ck_run) begin
      etu_cnt_ff <= 11'h000;
    end else if (etu_tick) begin
      etu_cnt_ff <= 11'h000;
    end else if (ck_tick) begin
      etu_cnt_ff <= etu_cnt_ff + 11'h001;
    end
  end
  // ==========================================================
  // guard and block guard counters
  logic gt_done, bgt_done, bgt_en_d_ff;
  assign gt_done = (gt_cnt_ff == gt_value);
  assign bgt_done = ~bgt_en | (bgt_cnt_ff == bgt_shadow_ff);
  assign tx_permit = gt_done & bgt_done & ~lock_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gt_cnt_ff <= {sct_pkg::RST_GT_HIGH[0], sct_pkg::RST_GT_LOW};
    end else if (tx_start) begin
      gt_cnt_ff <= sct_pkg::GT_INIT;
    end else if (etu_tick & ~gt_done) begin
      gt_cnt_ff <= gt_cnt_ff + 9'h001;
    end
  end
  // shadow of 9 bits reaches 511, i.e. 512 etus with the start etu
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bgt_en_d_ff <= 1'b0;
      bgt_shadow_ff <= 9'h000;
    end else begin
      bgt_en_d_ff <= bgt_en;
      if (bgt_en & ~bgt_en_d_ff) bgt_shadow_ff <= gt_value;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bgt_cnt_ff <= sct_pkg::BGT_INIT;
    end else if (bgt_en & rx_start) begin
      bgt_cnt_ff <= sct_pkg::BGT_INIT;
    end else if (tx_start) begin
      // terminal start re-arms to done so gt alone spaces tx chars
      bgt_cnt_ff <= bgt_shadow_ff;
    end else if (bgt_en & etu_tick & ~bgt_done) begin
      bgt_cnt_ff <= bgt_cnt_ff + 9'h001;
    end
  end
  // ==========================================================
  // waiting time counter
  logic wt_en_d_ff, wt_load, wt_rise, wt_fall;
  assign wt_rise = wt_en & ~wt_en_d_ff;
  assign wt_fall = ~wt_en & wt_en_d_ff;
  assign wt_load = (wr_en & (paddr == sct_pkg::ADDR_WT_B2) & ~wt_en);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wt_en_d_ff <= 1'b0;
      wt_cnt_ff <= 32'h0000_0000;
      wt_run_ff <= 1'b0;
      lock_ff <= 1'b0;
      wt_timeout <= 1'b0;
    end else begin
      wt_en_d_ff <= wt_en;
      wt_timeout <= 1'b0;
      if (wt_load) begin
        wt_cnt_ff <= {wt_b3_ff, pwdata[7:0], wt_b1_ff, wt_b0_ff};
        lock_ff <= 1'b0;
      end else if (wt_en & uart_mode & (tx_start | rx_start)) begin
        wt_cnt_ff <= wt_value;
        lock_ff <= 1'b0;
      end else if (wt_run_ff & etu_tick) begin
        if (wt_cnt_ff == 32'h0000_0001 || wt_cnt_ff == 32'h0000_0000) begin
          wt_cnt_ff <= 32'h0000_0000;
          lock_ff <= 1'b1;
          wt_timeout <= 1'b1;
        end else begin
          wt_cnt_ff <= wt_cnt_ff - 32'h0000_0001;
        end
      end
      if (wt_fall | (wt_run_ff & etu_tick & (wt_cnt_ff <= 32'h0000_0001)))
        wt_run_ff <= 1'b0;
      else if (wt_rise & ~lock_ff)
        wt_run_ff <= 1'b1;
      else if (wt_rise & wt_load)
        wt_run_ff <= 1'b1;
    end
  end
  assign if_locked = lock_ff;
  // ==========================================================
  // activation sequencer, times in card clocks
  logic [15:0] act_cnt_ff;
  logic act_cnt_clr, warm_req;
  sct_pkg::sct_act_type nxt_act;
  assign warm_req = ctrl_ff[sct_pkg::CTRL_WARM];
  always_comb begin
    nxt_act = act_ff;
    unique case (act_ff)
      sct_pkg::ACT_OFF: if (pres_ff & ~oc_ff) nxt_act = sct_pkg::ACT_POWER;
      sct_pkg::ACT_POWER:
        if (act_cnt_ff == 16'(sct_pkg::VCC_SETTLE_CLOCKS))
          nxt_act = sct_pkg::ACT_CLOCK;
      sct_pkg::ACT_CLOCK:
        if (act_cnt_ff == 16'(sct_pkg::TB_CLOCKS)) nxt_act = sct_pkg::ACT_ATR;
      sct_pkg::ACT_ATR:
        if ((~io_ff & act_cnt_ff >= 16'(sct_pkg::ATR_MIN_CLOCKS)) |
            act_cnt_ff == 16'(sct_pkg::ATR_MAX_CLOCKS))
          nxt_act = sct_pkg::ACT_RUN;
      sct_pkg::ACT_RUN: if (warm_req) nxt_act = sct_pkg::ACT_WARM;
      sct_pkg::ACT_WARM:
        if (act_cnt_ff == 16'(sct_pkg::TE_CLOCKS)) nxt_act = sct_pkg::ACT_ATR;
      sct_pkg::ACT_DEACT: if (act_cnt_ff == 16'h0003) nxt_act = sct_pkg::ACT_OFF;
      default: nxt_act = sct_pkg::ACT_DEACT;
    endcase
    if (act_ff != sct_pkg::ACT_OFF && act_ff != sct_pkg::ACT_DEACT &&
        (~pres_ff | oc_ff | ctrl_ff[sct_pkg::CTRL_DEACT]))
      nxt_act = sct_pkg::ACT_DEACT;
  end
  assign act_cnt_clr = (nxt_act != act_ff);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      act_ff <= sct_pkg::ACT_OFF;
      act_cnt_ff <= 16'h0000;
      atr_seen <= 1'b0;
      atr_late <= 1'b0;
    end else begin
      act_ff <= nxt_act;
      if (act_cnt_clr) act_cnt_ff <= 16'h0000;
      else if (ck_tick) act_cnt_ff <= act_cnt_ff + 16'h0001;
      if (act_ff == sct_pkg::ACT_ATR && nxt_act == sct_pkg::ACT_RUN) begin
        atr_seen <= ~io_ff;
        atr_late <= io_ff;
      end else if (act_ff != sct_pkg::ACT_RUN) begin
        atr_seen <= 1'b0;
        atr_late <= 1'b0;
      end
    end
  end
  // deactivation drops reset, then clock, then supply
  sct_pkg::sct_card_type card_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      card_ff <= '{rst_n: 1'b0, clk_en: 1'b0, vcc_en: 1'b0, io_rx: 1'b1};
    end else begin
      card_ff.io_rx <= 1'b1;
      card_ff.rst_n <= (act_ff == sct_pkg::ACT_ATR) | (act_ff == sct_pkg::ACT_RUN);
      card_ff.clk_en <= (act_ff != sct_pkg::ACT_OFF) &
        (act_ff != sct_pkg::ACT_POWER) &
        ~(act_ff == sct_pkg::ACT_DEACT && act_cnt_ff >= 16'h0001);
      card_ff.vcc_en <= (act_ff != sct_pkg::ACT_OFF) &
        ~(act_ff == sct_pkg::ACT_DEACT && act_cnt_ff >= 16'h0002);
    end
  end
  assign ck_run = card_ff.clk_en;
  assign card_clock = ck_ff & card_ff.clk_en;
  assign card_rst_n = card_ff.rst_n;
  assign card_vcc_en = card_ff.vcc_en;
  assign io_oe = ~card_ff.io_rx;
  // ==========================================================
  // assertions
  property p_gt_init;
    @(posedge mclk) disable iff (sys_rst) tx_start |=> gt_cnt_ff == 9'h001;
  endproperty
  a_gt_init: assert property (p_gt_init) else $error("guard not one");
  property p_gt_hold;
    @(posedge mclk) disable iff (sys_rst)
      (gt_done & ~tx_start) |=> gt_done | $changed(gt_value);
  endproperty
  a_gt_hold: assert property (p_gt_hold) else $error("guard left done");
  property p_bgt_clr;
    @(posedge mclk) disable iff (sys_rst)
      (bgt_en & rx_start) |=> bgt_cnt_ff == 9'h000;
  endproperty
  a_bgt_clr: assert property (p_bgt_clr) else $error("bgt not cleared");
  property p_shadow;
    @(posedge mclk) disable iff (sys_rst)
      $rose(bgt_en) |=> bgt_shadow_ff == $past(gt_value);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow missed");
  property p_wt_dec;
    @(posedge mclk) disable iff (sys_rst)
      (wt_run_ff & etu_tick & ~wt_load & ~(wt_en & uart_mode & (tx_start |
       rx_start)) & wt_cnt_ff > 32'h0000_0001) |=>
      wt_cnt_ff == $past(wt_cnt_ff) - 32'h0000_0001;
  endproperty
  a_wt_dec: assert property (p_wt_dec) else $error("wt not dec");
  property p_lock;
    @(posedge mclk) disable iff (sys_rst)
      wt_timeout |-> lock_ff & ~tx_permit;
  endproperty
  a_lock: assert property (p_lock) else $error("no lock");
  property p_wt_load;
    @(posedge mclk) disable iff (sys_rst)
      wt_load |=> wt_cnt_ff == wt_value;
  endproperty
  a_wt_load: assert property (p_wt_load) else $error("wt load");
  property p_warm;
    @(posedge mclk) disable iff (sys_rst)
      (act_ff == sct_pkg::ACT_WARM && nxt_act == sct_pkg::ACT_ATR) |->
      act_cnt_ff >= 16'h0190;
  endproperty
  a_warm: assert property (p_warm) else $error("warm short");
  property p_remove;
    @(posedge mclk) disable iff (sys_rst)
      (~pres_ff & act_ff == sct_pkg::ACT_RUN) |=> act_ff == sct_pkg::ACT_DEACT;
  endproperty
  a_remove: assert property (p_remove) else $error("no deact");
  c_timeout: cover property (@(posedge mclk) disable iff (sys_rst) wt_timeout);
  c_run: cover property (@(posedge mclk) disable iff (sys_rst)
    act_ff == sct_pkg::ACT_RUN);
  c_bgt: cover property (@(posedge mclk) disable iff (sys_rst)
    bgt_en & bgt_done & rx_start);
endmodule // sct_timing

// file: tb/sct_card_model.sv
// card model: answers reset with a start bit after a fixed delay
// assumes card_clock runs only while the interface drives it
`timescale 1ns/100ps
module sct_card_model #(
  parameter int ATR_DELAY = 420
) (
  input wire logic card_clock, // clock from terminal
  input wire logic card_rst_n, // reset from terminal
  input wire logic card_vcc_en, // supply from terminal
  output logic io_line // i/o level seen by terminal
);
  // =========================================================
  // answer to reset
  // line has a pull-up, so released means high
  initial begin
    io_line = 1'b1;
    forever begin
      @(posedge card_rst_n);
      if (card_vcc_en === 1'b1) begin
        repeat (ATR_DELAY) @(posedge card_clock);
        io_line = 1'b0;
        repeat (10) @(posedge card_clock);
        io_line = 1'b1;
      end
    end
  end
endmodule // sct_card_model

// file: tb/tb_sct_timing.sv
// bench for the timing counters and activation sequencer
// assumes sct_timing with apb registers and a card model on the pins
`timescale 1ns/100ps
module tb_sct_timing;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic card_present, overcurrent, io_in, tx_start, rx_start, tx_permit;
  logic wt_timeout, if_locked, atr_seen, atr_late, card_clock;
  logic card_rst_n, card_vcc_en, io_oe, err;
  int miscompares, cmp_count, ck_cnt, to_cnt, n, c0, v, e;
  sct_timing dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_present(card_present), .overcurrent(overcurrent), .io_in(io_in),
    .tx_start(tx_start), .rx_start(rx_start), .tx_permit(tx_permit),
    .wt_timeout(wt_timeout), .if_locked(if_locked), .atr_seen(atr_seen),
    .atr_late(atr_late), .card_clock(card_clock), .card_rst_n(card_rst_n),
    .card_vcc_en(card_vcc_en), .io_oe(io_oe));
  sct_card_model card_u (.card_clock(card_clock), .card_rst_n(card_rst_n),
    .card_vcc_en(card_vcc_en), .io_line(io_in));
  // =========================================================
  // clock, monitors, watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge card_clock) ck_cnt++;
  always @(posedge mclk) if (wt_timeout === 1'b1) to_cnt++;
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    close_out;
  end
  // =========================================================
  // compare and bus tasks
  task close_out;
    $display("compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk_val(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: exp %0h got %0h", $time, exp, got);
    end
  endtask
  task chk_rng(input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected at %0t: exp %0h..%0h got %0h", $time, lo, hi,
        got);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait limit here; only the watchdog ends a stuck transfer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // polls a level once a cycle; a limit reached is a mismatch
  task automatic wait_lvl(ref logic s, input logic l, input int lim);
    n = 0;
    while (s !== l && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= lim) chk_val(l, s);
  endtask
  task pulse(input logic is_rx);
    @(posedge mclk);
    if (is_rx) rx_start <= 1'b1;
    else tx_start <= 1'b1;
    @(posedge mclk);
    rx_start <= 1'b0;
    tx_start <= 1'b0;
  endtask
  task wait_run;
    int k;
    k = 0;
    do begin
      apb(1'b0, sct_pkg::ADDR_STAT, 32'h0);
      k++;
    end while (rd[6:4] !== sct_pkg::ACT_RUN && k < 12000);
    chk_val(sct_pkg::ACT_RUN, rd[6:4]);
  endtask
  function int lo_etu(input int cnt);
    return (cnt - 1) * e;
  endfunction
  function int hi_etu(input int cnt);
    return (cnt + 1) * e;
  endfunction
  // guard: count starts at one, so value-1 etus of hold-off
  task guard_meas(input int gv);
    pulse(1'b0);
    #1;
    wait_lvl(tx_permit, 1'b1, 40 * e);
    chk_rng(lo_etu(gv - 1), hi_etu(gv - 1), n);
  endtask
  // =========================================================
  // main sequence
  initial begin
    logic [7:0] addrs [6];
    logic [7:0] rsts [6];
    addrs = '{sct_pkg::ADDR_GT_HIGH, sct_pkg::ADDR_GT_LOW,
      sct_pkg::ADDR_WT_B3, sct_pkg::ADDR_WT_B2, sct_pkg::ADDR_WT_B1,
      sct_pkg::ADDR_WT_B0};
    rsts = '{sct_pkg::RST_GT_HIGH, sct_pkg::RST_GT_LOW, sct_pkg::RST_WT_B3,
      sct_pkg::RST_WT_B2, sct_pkg::RST_WT_B1, sct_pkg::RST_WT_B0};
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h00_0000_0000};
    {card_present, overcurrent, tx_start, rx_start} = 4'h0;
    e = 100;
    void'($urandom(32'h3559));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, addrs[i], 32'h0);
      chk_val(rsts[i], rd);
    end
    apb(1'b0, sct_pkg::ADDR_ETU, 32'h0);
    chk_val(sct_pkg::RST_ETU, rd);
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk_val(32'h1, err);
    apb(1'b0, 8'h24, 32'h0);
    chk_val(32'h0, rd);
    v = $urandom;
    apb(1'b1, sct_pkg::ADDR_WT_B1, v);
    apb(1'b0, sct_pkg::ADDR_WT_B1, 32'h0);
    chk_val(v & 32'hFF, rd);
    // cold activation: reset low until clock runs, then released
    card_present <= 1'b1;
    wait_lvl(card_vcc_en, 1'b1, 5000);
    chk_val(1'b0, card_rst_n);
    wait_lvl(card_clock, 1'b1, 20000);
    c0 = ck_cnt;
    wait_lvl(card_rst_n, 1'b1, 30000);
    chk_rng(1, 399, ck_cnt - c0);
    wait_run;
    chk_val(2'b10, {atr_seen, atr_late});
    chk_val(1'b0, io_oe);
    apb(1'b1, sct_pkg::ADDR_ETU, 32'h2);
    repeat (3) begin
      v = $urandom % 18 + 3;
      apb(1'b1, sct_pkg::ADDR_GT_LOW, v);
      apb(1'b0, sct_pkg::ADDR_GT_LOW, 32'h0);
      chk_val(v, rd);
      guard_meas(v);
    end
    // block guard set-up order, shadow keeps 21 after low byte is 12
    apb(1'b1, sct_pkg::ADDR_GT_HIGH, 32'h0);
    apb(1'b1, sct_pkg::ADDR_GT_LOW, 32'h15);
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, sct_pkg::ADDR_GT_LOW, 32'hC);
    // a held count above the new value would run round 512 etus
    pulse(1'b0);
    pulse(1'b1);
    #1;
    wait_lvl(tx_permit, 1'b1, 40 * e);
    chk_rng(lo_etu(21), hi_etu(21), n);
    guard_meas(12);
    // waiting time: manual load, start on enable rise, expiry locks
    v = $urandom % 7 + 4;
    apb(1'b1, sct_pkg::ADDR_WT_B3, 32'h0);
    apb(1'b1, sct_pkg::ADDR_WT_B1, 32'h0);
    apb(1'b1, sct_pkg::ADDR_WT_B0, v);
    apb(1'b1, sct_pkg::ADDR_WT_B2, 32'h0);
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h3);
    wait_lvl(wt_timeout, 1'b1, 20 * e);
    chk_rng(lo_etu(v), hi_etu(v), n);
    chk_val(2'b10, {if_locked, tx_permit});
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, sct_pkg::ADDR_WT_B0, 32'h8);
    apb(1'b1, sct_pkg::ADDR_WT_B2, 32'h0);
    wait_lvl(if_locked, 1'b0, 4);
    // uart mode: start bits keep reloading, so no expiry until they stop
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h7);
    to_cnt = 0;
    repeat (5) begin
      repeat (4 * e) @(posedge mclk);
      pulse(1'b1);
    end
    // next limit written mid-character, taken at the next start bit
    apb(1'b1, sct_pkg::ADDR_WT_B0, 32'h5);
    pulse(1'b0);
    chk_val(32'h0, to_cnt);
    #1;
    wait_lvl(wt_timeout, 1'b1, 20 * e);
    chk_rng(lo_etu(5), hi_etu(5), n);
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, sct_pkg::ADDR_WT_B2, 32'h0);
    // warm reset
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h9);
    wait_lvl(card_rst_n, 1'b0, 500);
    c0 = ck_cnt;
    apb(1'b1, sct_pkg::ADDR_CTRL, 32'h1);
    wait_lvl(card_rst_n, 1'b1, 25000);
    chk_rng(400, 410, ck_cnt - c0);
    wait_run;
    chk_val(2'b10, {atr_seen, atr_late});
    // removal powers the card down
    card_present <= 1'b0;
    wait_lvl(card_vcc_en, 1'b0, 1000);
    chk_val(2'b00, {card_rst_n, io_oe});
    close_out;
  end
endmodule // tb_sct_timing
